// ### rtl/pot_cmd_decoder.sv
// Serial command decoder for the four wipers and their saved settings.
`timescale 1ns/1ps
module pot_cmd_decoder #(
  parameter int NV_CYCLES = pot_cmd_pkg::NV_WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic addr_strap_hi,
  input wire logic addr_strap_lo,
  output logic so,
  output logic so_oe,
  output logic [4*pot_cmd_pkg::TAP_W-1:0] wiper_taps,
  output logic nv_write_pending
);
  localparam int TW = pot_cmd_pkg::TAP_W;

  function automatic logic [TW-1:0] step_tap(input logic [TW-1:0] t,
                                             input logic up);
    if (up) begin
      step_tap = (t == pot_cmd_pkg::TAP_MAX) ? t : t + 6'h01;
    end else begin
      step_tap = (t == 6'h00) ? t : t - 6'h01;
    end
  endfunction : step_tap

  //////////////////////////////////////////////////////////////////////////
  // Link domain. The frame logic runs on sck and is reset by cs_n high,
  // since sck may stand still between frames.
  pot_cmd_pkg::frame_state_type state;
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic [1:0] pot_sel;
  logic link_req_tog;
  logic [3:0] link_op;
  logic [1:0] link_reg_sel;
  logic [1:0] link_pot_sel;
  logic [3:0] step_tog;
  logic [3:0] step_dir;
  logic [2:0] st_bit;
  logic busy_s1, busy_s2;
  logic [7:0] byte_in;

  assign byte_in = {shift, si};

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      state <= pot_cmd_pkg::ST_ADDR;
      bit_cnt <= 3'h0;
      shift <= 7'h00;
      pot_sel <= 2'h0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shift <= byte_in[6:0];
      case (state)
        pot_cmd_pkg::ST_ADDR: begin
          if (bit_cnt == pot_cmd_pkg::BIT_LAST) begin
            if (byte_in[7:2] == pot_cmd_pkg::ADDR_PREFIX &&
                byte_in[1:0] == {addr_strap_hi, addr_strap_lo}) begin
              state <= pot_cmd_pkg::ST_INSTR;
            end else begin
              state <= pot_cmd_pkg::ST_IGNORE;
            end
          end
        end
        pot_cmd_pkg::ST_INSTR: begin
          if (bit_cnt == pot_cmd_pkg::BIT_LAST) begin
            pot_sel <= byte_in[1:0];
            if (byte_in[7:2] == {pot_cmd_pkg::OP_STEP, 2'h0}) begin
              state <= pot_cmd_pkg::ST_STEP;
            end else if (byte_in == pot_cmd_pkg::OP_STATUS) begin
              state <= pot_cmd_pkg::ST_STATUS;
            end else begin
              state <= pot_cmd_pkg::ST_IGNORE;
            end
          end
        end
        pot_cmd_pkg::ST_STEP: state <= pot_cmd_pkg::ST_STEP;
        pot_cmd_pkg::ST_STATUS: state <= pot_cmd_pkg::ST_STATUS;
        pot_cmd_pkg::ST_IGNORE: state <= pot_cmd_pkg::ST_IGNORE;
        default: state <= pot_cmd_pkg::ST_IGNORE;
      endcase
    end
  end

  // Transfer commands are latched at the end of the instruction byte and
  // handed to the system domain by a toggle, which then waits for cs_n.
  // The toggles are cleared by srst directly, since sck may not run while
  // reset is held and an unknown toggle would never be seen to change.
  always_ff @(posedge sck or posedge srst) begin
    if (srst) begin
      link_op <= 4'h0;
      link_reg_sel <= 2'h0;
      link_pot_sel <= 2'h0;
      link_req_tog <= 1'b0;
    end else if (state == pot_cmd_pkg::ST_INSTR
                 && bit_cnt == pot_cmd_pkg::BIT_LAST && !cs_n) begin
      link_op <= byte_in[7:4];
      link_reg_sel <= byte_in[3:2];
      link_pot_sel <= byte_in[1:0];
      link_req_tog <= ~link_req_tog;
    end
  end

  // Each step pulse crosses as a toggle per pot, with its direction.
  always_ff @(posedge sck or posedge srst) begin
    if (srst) begin
      step_dir <= 4'h0;
      step_tog <= 4'h0;
    end else if (state == pot_cmd_pkg::ST_STEP && !cs_n) begin
      step_dir[pot_sel] <= si;
      step_tog[pot_sel] <= ~step_tog[pot_sel];
    end
  end

  // Status byte shifts out on the falling edge, write flag in bit 0.
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so <= 1'b0;
      so_oe <= 1'b0;
      st_bit <= 3'h0;
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
    end else begin
      busy_s1 <= nv_write_pending;
      busy_s2 <= busy_s1;
      so_oe <= (state == pot_cmd_pkg::ST_STATUS);
      if (state == pot_cmd_pkg::ST_STATUS) begin
        st_bit <= st_bit + 3'h1;
        so <= (st_bit == pot_cmd_pkg::BIT_LAST) ? busy_s2 : 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // System domain.
  logic [2:0] req_sync;
  logic [2:0] cs_sync;
  logic [3:0] tog_sync [4];
  logic [1:0] dir_sync [4];
  logic req_pending;
  logic [3:0] op_q;
  logic [1:0] reg_q, pot_q;
  logic [31:0] nv_cnt;
  logic [TW-1:0] tap [4];
  logic [TW-1:0] setting [4][4];

  always_ff @(posedge clk) begin
    if (srst) begin
      req_sync <= 3'h0;
      cs_sync <= 3'h7;
    end else begin
      req_sync <= {req_sync[1:0], link_req_tog};
      cs_sync <= {cs_sync[1:0], cs_n};
    end
  end

  always_ff @(posedge clk) begin
    for (int p = 0; p < 4; p++) begin
      if (srst) begin
        tog_sync[p] <= 4'h0;
        dir_sync[p] <= 2'h0;
      end else begin
        tog_sync[p] <= {tog_sync[p][2:0], step_tog[p]};
        dir_sync[p] <= {dir_sync[p][0], step_dir[p]};
      end
    end
  end

  // Command fields are stable once the toggle is seen, since sck is idle
  // or the frame has moved past the instruction byte.
  always_ff @(posedge clk) begin
    if (srst) begin
      req_pending <= 1'b0;
      op_q <= 4'h0;
      reg_q <= 2'h0;
      pot_q <= 2'h0;
    end else if (req_sync[2] != req_sync[1]) begin
      req_pending <= 1'b1;
      op_q <= link_op;
      reg_q <= link_reg_sel;
      pot_q <= link_pot_sel;
    end else if (cs_sync[2]) begin
      req_pending <= 1'b0;
    end
  end

  logic exec;
  assign exec = req_pending && cs_sync[2];

  always_ff @(posedge clk) begin
    for (int p = 0; p < 4; p++) begin
      if (srst) begin
        tap[p] <= pot_cmd_pkg::TAP_RESET;
      end else if (exec && op_q == pot_cmd_pkg::OP_GLOBAL_LOAD
                   && pot_q == 2'h0) begin
        tap[p] <= setting[p][reg_q];
      end else if (exec && op_q == pot_cmd_pkg::OP_LOAD
                   && pot_q == 2'(p)) begin
        tap[p] <= setting[p][reg_q];
      end else if (tog_sync[p][3] != tog_sync[p][2]) begin
        // The step waits one cycle past the synchronised toggle, so the
        // direction, which may resolve a cycle later, has settled.
        tap[p] <= step_tap(tap[p], dir_sync[p][1]);
      end
    end
  end

  // Saves land only after cs_n is back high.
  always_ff @(posedge clk) begin
    for (int p = 0; p < 4; p++) begin
      for (int r = 0; r < 4; r++) begin
        if (srst) begin
          setting[p][r] <= pot_cmd_pkg::TAP_RESET;
        end else if (exec && !nv_write_pending && reg_q == 2'(r) &&
                     ((op_q == pot_cmd_pkg::OP_GLOBAL_SAVE && pot_q == 2'h0)
                      || (op_q == pot_cmd_pkg::OP_SAVE
                          && pot_q == 2'(p)))) begin
          setting[p][r] <= tap[p];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      nv_cnt <= 32'h0;
      nv_write_pending <= 1'b0;
    end else if (exec && !nv_write_pending &&
                 ((op_q == pot_cmd_pkg::OP_GLOBAL_SAVE && pot_q == 2'h0)
                  || op_q == pot_cmd_pkg::OP_SAVE)) begin
      nv_cnt <= 32'(NV_CYCLES);
      nv_write_pending <= 1'b1;
    end else if (nv_cnt > 32'h1) begin
      nv_cnt <= nv_cnt - 32'h1;
    end else begin
      nv_cnt <= 32'h0;
      nv_write_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wiper_taps <= '0;
    end else begin
      wiper_taps <= {tap[3], tap[2], tap[1], tap[0]};
    end
  end
endmodule : pot_cmd_decoder

// ### inc/pot_cmd_pkg.sv
// Shared constants and types for the quad potentiometer command decoder.
package pot_cmd_pkg;
  localparam int TAP_W = 6;
  localparam int NUM_POTS = 4;
  localparam int NUM_SETTINGS = 4;
  localparam logic [TAP_W-1:0] TAP_MAX = 6'h3f;
  localparam logic [TAP_W-1:0] TAP_RESET = 6'h00;
  localparam logic [5:0] ADDR_PREFIX = 6'h14;
  localparam logic [3:0] OP_GLOBAL_LOAD = 4'h1;
  localparam logic [3:0] OP_GLOBAL_SAVE = 4'h8;
  localparam logic [3:0] OP_SAVE = 4'he;
  localparam logic [3:0] OP_LOAD = 4'hd;
  localparam logic [3:0] OP_STEP = 4'h2;
  localparam logic [7:0] OP_STATUS = 8'h51;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int NV_WRITE_TIME_US = 5000;
  localparam int CLK_MHZ = 20;
  localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * CLK_MHZ;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [4:0] {
    ST_ADDR = 5'h01,
    ST_INSTR = 5'h02,
    ST_STEP = 5'h04,
    ST_STATUS = 5'h08,
    ST_IGNORE = 5'h10
  } frame_state_type;
endpackage : pot_cmd_pkg

// ### tb/pot_cmd_asserts.sv
// Port-level checks for the potentiometer command decoder.
`timescale 1ns/1ps
module pot_cmd_asserts #(
  parameter int NV_CYCLES = 20
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic addr_strap_hi,
  input wire logic addr_strap_lo,
  input wire logic so,
  input wire logic so_oe,
  input wire logic [4*pot_cmd_pkg::TAP_W-1:0] wiper_taps,
  input wire logic nv_write_pending
);
  int busy_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  always_ff @(posedge clk) begin
    busy_cnt <= (nv_write_pending && !srst) ? busy_cnt + 1 : 0;
  end
  sequence in_frame; !cs_n [*3]; endsequence
  sequence quiet; cs_n [*8]; endsequence
  chk_nv_after_cs: assert property ($rose(nv_write_pending) |-> cs_n)
    else $error("write began inside a frame");
  chk_nv_in_frame: assert property (in_frame |-> !$rose(nv_write_pending))
    else $error("write began while selected");
  chk_nv_length: assert property ($fell(nv_write_pending) |-> busy_cnt == NV_CYCLES)
    else $error("write time wrong");
  chk_nv_bound: assert property (nv_write_pending |-> busy_cnt < NV_CYCLES)
    else $error("write time overrun");
  chk_taps_settle: assert property (quiet |-> $stable(wiper_taps))
    else $error("taps moved while idle");
  chk_step_one: assert property ((!cs_n && !$past(cs_n) && $changed(wiper_taps[5:0]))
    |-> 6'(wiper_taps[5:0] - $past(wiper_taps[5:0])) inside {6'h01, 6'h3f})
    else $error("step moved more than one tap");
  chk_oe_frame: assert property (so_oe |-> !cs_n)
    else $error("output driven outside frame");
  chk_so_idle: assert property (!so_oe |-> !so)
    else $error("output not low when idle");
  chk_reset_out: assert property ($fell(srst) |-> wiper_taps == '0 && !nv_write_pending)
    else $error("outputs not cleared by reset");
endmodule : pot_cmd_asserts

// ### tb/spi_host.sv
// Behavioural SPI host that frames commands for the decoder.
`timescale 1ns/1ps
module spi_host (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  logic [7:0] rx;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    rx = 8'h00;
  end
  // A bit is one 30 ns clock; step bits add a gap the decoder needs.
  task automatic bits(input logic [7:0] v, input int n, input int gap);
    for (int i = n - 1; i >= 0; i--) begin
      si = v[i];
      #15 sck = 1'b1;
      rx = {rx[6:0], so};
      #15 sck = 1'b0;
      #(gap);
    end
  endtask : bits
  task automatic frame_open(input logic [1:0] adr, input logic [7:0] ins);
    cs_n = 1'b0;
    #40 bits({pot_cmd_pkg::ADDR_PREFIX, adr}, 8, 0);
    bits(ins, 8, 0);
  endtask : frame_open
  // The data line is not held after the frame, so it is turned over.
  // Chip select then stays high long enough for a transfer to complete.
  task automatic frame_close();
    #40 cs_n = 1'b1;
    si = ~si;
    #300;
  endtask : frame_close
endmodule : spi_host

// ### tb/testbench.sv
// Self-checking bench for the potentiometer command decoder.
`timescale 1ns/1ps
module testbench;
  localparam int NV_CYCLES = 60;
  logic clk = 1'b0;
  logic srst = 1'b0;
  logic [1:0] strap = 2'h0;
  logic sck, cs_n, si, so, so_oe, busy;
  logic [4*pot_cmd_pkg::TAP_W-1:0] taps;
  logic [5:0] wiper [4];
  logic [5:0] saved [4][4];
  int failures = 0;
  int tests_run = 0;
  initial begin
    forever #25 clk = ~clk;
  end
  spi_host host_u (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
  pot_cmd_decoder #(.NV_CYCLES(NV_CYCLES)) dut_u (.clk(clk), .srst(srst),
    .sck(sck), .cs_n(cs_n), .si(si), .addr_strap_hi(strap[1]),
    .addr_strap_lo(strap[0]), .so(so), .so_oe(so_oe),
    .wiper_taps(taps), .nv_write_pending(busy));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] stepped(input logic [5:0] w, input logic u);
    if (u) return (w == pot_cmd_pkg::TAP_MAX) ? w : w + 6'h01;
    return (w == 6'h00) ? w : w - 6'h01;
  endfunction : stepped
  task automatic stop_test();
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_idle();
    for (int i = 0; busy !== 1'b0; i++) begin
      if (i > 200) begin
        failures++;
        stop_test();
      end
      @(posedge clk);
    end
  endtask : wait_idle
  task automatic status(input logic exp);
    host_u.frame_open(strap, pot_cmd_pkg::OP_STATUS);
    host_u.bits(8'h00, 8, 0);
    host_u.frame_close();
    check(host_u.rx[0], exp);
  endtask : status
  // Runs a frame and settles it; how[1] forces the direction how[0].
  task automatic step(input logic [1:0] p, input int n, input logic [1:0] how);
    logic d;
    host_u.frame_open(strap, {pot_cmd_pkg::OP_STEP, 2'h0, p});
    for (int i = 0; i < n; i++) begin
      d = how[1] ? how[0] : 1'($urandom);
      host_u.bits({7'h00, d}, 1, 200);
      wiper[p] = stepped(wiper[p], d);
    end
    host_u.frame_close();
    repeat (10) @(posedge clk);
    check(taps, {wiper[3], wiper[2], wiper[1], wiper[0]});
  endtask : step
  task automatic cmd(input logic [1:0] adr, input logic [7:0] ins);
    logic [1:0] r;
    logic [1:0] p;
    r = ins[3:2];
    p = ins[1:0];
    host_u.frame_open(adr, ins);
    host_u.frame_close();
    repeat (10) @(posedge clk);
    for (int i = 0; i < 4 && adr == strap; i++) begin
      case (ins[7:4])
        pot_cmd_pkg::OP_GLOBAL_LOAD: if (p == 2'h0) wiper[i] = saved[i][r];
        pot_cmd_pkg::OP_GLOBAL_SAVE: if (p == 2'h0) saved[i][r] = wiper[i];
        pot_cmd_pkg::OP_SAVE: if (p == i) saved[i][r] = wiper[i];
        pot_cmd_pkg::OP_LOAD: if (p == i) wiper[i] = saved[i][r];
        default: ;
      endcase
    end
    check(taps, {wiper[3], wiper[2], wiper[1], wiper[0]});
  endtask : cmd
  initial begin
    void'($urandom(32'hf800));
    wiper = '{default: 6'h00};
    saved = '{default: '{default: 6'h00}};
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    strap <= 2'($urandom);
    repeat (2) @(posedge clk);
    check(taps, 24'h0);
    step(2'h0, 3, 2'b10);
    step(2'h0, 70, 2'b11);
    for (int k = 0; k < 8; k++) begin
      step(2'($urandom), 12, 2'b00);
      cmd(strap, {pot_cmd_pkg::OP_SAVE, 4'($urandom)});
      check(busy, 1'b1);
      status(1'b1);
      wait_idle();
      status(1'b0);
      cmd(strap, {pot_cmd_pkg::OP_GLOBAL_SAVE, 4'($urandom)});
      wait_idle();
      step(2'($urandom), 12, 2'b00);
      cmd(strap, {pot_cmd_pkg::OP_LOAD, 4'($urandom)});
      cmd(strap, {pot_cmd_pkg::OP_GLOBAL_LOAD, 4'($urandom)});
      cmd(strap ^ 2'h1, {pot_cmd_pkg::OP_GLOBAL_LOAD, 4'h0});
    end
    stop_test();
  end
endmodule : testbench
bind pot_cmd_decoder pot_cmd_asserts #(.NV_CYCLES(NV_CYCLES)) chk_u (
  .clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n), .si(si),
  .addr_strap_hi(addr_strap_hi), .addr_strap_lo(addr_strap_lo), .so(so),
  .so_oe(so_oe), .wiper_taps(wiper_taps),
  .nv_write_pending(nv_write_pending));
